// ---- hdl/pbs_cfg_decode.sv ----
// Decodes a type-0 configuration access on the primary side.
// Assumes the access fields are stable in the cycle that valid is high.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_params.svh"

module pbs_cfg_decode (
    input  wire pbs_pkg::pbs_cfg_s cfg,
    input  wire logic [2:0]        fn_num,
    output var  pbs_pkg::pbs_dec_s dec
);
    import pbs_pkg::*;

    function automatic logic is_self(input pbs_cfg_s c, input logic [2:0] fn);
        is_self = c.valid && c.idsel
                  && (c.ad[1:0] == `PBS_TYPE0_CODE)
                  && (c.ad[`PBS_AD_FN_MSB:`PBS_AD_FN_LSB] == fn);
    endfunction

    always_comb begin
        dec.self_wr = is_self(cfg, fn_num) && cfg.write;
        dec.self_rd = is_self(cfg, fn_num) && !cfg.write;
        dec.reg_hit = (cfg.ad[`PBS_DWORD_MSB:`PBS_DWORD_LSB]
                       == 6'(`PBS_OFS_STATUS >> `PBS_DWORD_LSB));
        dec.dev     = cfg.ad[`PBS_AD_DEV_MSB:`PBS_AD_DEV_LSB];
    end

endmodule // pbs_cfg_decode

`default_nettype wire

// ---- hdl/pbs_params.svh ----
// Constants for the bridge status register block: offsets, field positions,
// reset values and encodings. Assumes it is included by bare name.
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offset and access decode
// ----------------------------------------------------------------------------
`define PBS_OFS_STATUS        8'h84
`define PBS_TYPE0_CODE        2'h0
`define PBS_DWORD_LSB         2
`define PBS_DWORD_MSB         7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PBS_FN_LSB            0
`define PBS_FN_MSB            2
`define PBS_DEV_LSB           3
`define PBS_DEV_MSB           7
`define PBS_BUS_LSB           8
`define PBS_BUS_MSB           15
`define PBS_BIT_64B           16
`define PBS_BIT_133           17
`define PBS_BIT_DISC          18
`define PBS_BIT_UNEXP         19
`define PBS_BIT_OVRN          20
`define PBS_BIT_DELAY         21
`define PBS_AD_FN_LSB         8
`define PBS_AD_FN_MSB         10
`define PBS_AD_DEV_LSB        11
`define PBS_AD_DEV_MSB        15
`define PBS_BE_UPPER          2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PBS_FN_RST            3'h0
`define PBS_DEV_RST           5'h1F
`define PBS_BUS_RST           8'hFF
`define PBS_LIMIT_RST         16'h0010
`define PBS_ADQ_ZERO          17'h00000

`endif

// ---- hdl/pbs_pkg.sv ----
// Types shared by the bridge status register block.
// Assumes pbs_params.svh is on the include path.
package pbs_pkg;

    // ------------------------------------------------------------------------
    // Configuration access carried from the primary bus front end
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        idsel;
        logic [31:0] ad;
        logic [31:0] wdata;
        logic [3:0]  be;
    } pbs_cfg_s;

    // ------------------------------------------------------------------------
    // Split traffic events
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [15:0] req_id;
        logic [15:0] adq;
    } pbs_scmp_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] adq;
    } pbs_sreq_s;

    typedef struct packed {
        logic self_wr;
        logic self_rd;
        logic reg_hit;
        logic [4:0] dev;
    } pbs_dec_s;

    typedef enum logic [1:0] {
        PBS_ST_STRAP = 2'b00,
        PBS_ST_RUN   = 2'b01
    } pbs_phase_e;

endpackage

// ---- hdl/pbs_status.sv ----
// Bridge status register at offset 84h with its device number capture,
// completer ID build and split transaction error flags.
// Assumes configuration accesses arrive as one-cycle strobes from the
// primary bus front end, synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_params.svh"

module pbs_status (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                reverse_mode,
    input  wire pbs_pkg::pbs_cfg_s   cfg,
    input  wire logic [7:0]          prim_bus_num,
    input  wire pbs_pkg::pbs_scmp_s  scmp,
    input  wire pbs_pkg::pbs_sreq_s  sreq,
    input  wire logic                limit_load,
    input  wire logic [15:0]         limit_value,
    input  wire logic                adq_release,
    input  wire logic [15:0]         adq_release_cnt,
    output logic                     rd_valid,
    output logic [31:0]              rd_data,
    output logic                     cpl_id_valid,
    output logic [15:0]              cpl_id,
    output logic                     sreq_accept,
    output logic                     sreq_delay,
    output logic [15:0]              adq_outstanding
);
    import pbs_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        pbs_phase_e  phase;
        logic        reverse;
        logic [4:0]  dev;
        logic [7:0]  bus;
        logic        unexp;
        logic        delayed;
        logic [15:0] limit;
        logic [16:0] used;
        logic        rd_valid;
        logic [31:0] rd_data;
        logic        cpl_valid;
        logic [15:0] cpl_id;
        logic        acc;
        logic        dly;
    } pbs_state_s;

    pbs_state_s state_reg;
    pbs_state_s state_next;
    pbs_dec_s   dec;

    // Function number is fixed; the bridge has a single function.
    // fixed function field
    localparam logic [2:0] FN_NUM = `PBS_FN_RST;

    pbs_cfg_decode u_dec (
        .cfg    (cfg),
        .fn_num (FN_NUM),
        .dec    (dec)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [15:0] make_id(input logic [7:0] b,
                                            input logic [4:0] d,
                                            input logic [2:0] f);
        make_id = {b, d, f};
    endfunction

    function automatic logic [31:0] pack_status(input pbs_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`PBS_FN_MSB:`PBS_FN_LSB]   = FN_NUM;
        w[`PBS_DEV_MSB:`PBS_DEV_LSB] = s.dev;
        w[`PBS_BUS_MSB:`PBS_BUS_LSB] = s.bus;
        w[`PBS_BIT_64B]   = 1'b0;
        w[`PBS_BIT_133]   = s.reverse;
        w[`PBS_BIT_DISC]  = 1'b0;
        w[`PBS_BIT_OVRN]  = 1'b0;
        w[`PBS_BIT_UNEXP] = s.unexp;
        w[`PBS_BIT_DELAY] = s.delayed;
        pack_status = w;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic        wr_status;
        logic        clr_unexp;
        logic        clr_delay;
        logic        set_unexp;
        logic [16:0] want;
        logic [16:0] after_rel;
        wr_status = 1'b0;
        clr_unexp = 1'b0;
        clr_delay = 1'b0;
        set_unexp = 1'b0;
        want      = `PBS_ADQ_ZERO;
        after_rel = `PBS_ADQ_ZERO;
        state_next           = state_reg;
        state_next.rd_valid  = 1'b0;
        state_next.cpl_valid = 1'b0;
        state_next.acc       = 1'b0;
        state_next.dly       = 1'b0;

        // Mode strap is caught once, just after reset is released, so an
        // asynchronous reset never loads a port value.
        case (state_reg.phase)
            PBS_ST_STRAP: begin
                state_next.reverse = reverse_mode;
                state_next.phase   = PBS_ST_RUN;
            end
            PBS_ST_RUN: begin
                state_next.phase = PBS_ST_RUN;
            end
            default: begin
                state_next.phase = PBS_ST_STRAP;
            end
        endcase

        state_next.bus = prim_bus_num;

        if (dec.self_wr) begin
            state_next.dev = dec.dev;
        end

        wr_status = dec.self_wr && dec.reg_hit && cfg.be[`PBS_BE_UPPER];
        clr_unexp = wr_status && cfg.wdata[`PBS_BIT_UNEXP];
        clr_delay = wr_status && cfg.wdata[`PBS_BIT_DELAY];
        if (state_reg.reverse) begin
            clr_unexp = 1'b0;
        end

        set_unexp = scmp.valid
                    && (scmp.req_id == make_id(state_reg.bus, state_reg.dev, FN_NUM));
        // A set in the same cycle as a clear wins, so no event is lost.
        if (set_unexp) begin
            state_next.unexp = 1'b1;
        end else if (clr_unexp) begin
            state_next.unexp = 1'b0;
        end

        if (limit_load) begin
            state_next.limit = limit_value;
        end

        after_rel = state_reg.used;
        if (adq_release) begin
            if ({1'b0, adq_release_cnt} > after_rel) begin
                after_rel = `PBS_ADQ_ZERO;
            end else begin
                after_rel = after_rel - {1'b0, adq_release_cnt};
            end
        end
        state_next.used = after_rel;

        want = after_rel + {1'b0, sreq.adq};
        if (sreq.valid) begin
            if (want > {1'b0, state_reg.limit}) begin
                state_next.dly = 1'b1;
            end else begin
                state_next.acc  = 1'b1;
                state_next.used = want;
            end
        end
        if (sreq.valid && (want > {1'b0, state_reg.limit})) begin
            state_next.delayed = 1'b1;
        end else if (clr_delay) begin
            state_next.delayed = 1'b0;
        end

        if (dec.self_rd) begin
            state_next.rd_valid  = 1'b1;
            state_next.rd_data   = dec.reg_hit ? pack_status(state_reg) : 32'h0000_0000;
            state_next.cpl_valid = 1'b1;
            state_next.cpl_id    = make_id(state_reg.bus, state_reg.dev, FN_NUM);
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg.phase     <= PBS_ST_STRAP;
            state_reg.reverse   <= 1'b0;
            state_reg.dev       <= `PBS_DEV_RST;
            state_reg.bus       <= `PBS_BUS_RST;
            state_reg.unexp     <= 1'b0;
            state_reg.delayed   <= 1'b0;
            state_reg.limit     <= `PBS_LIMIT_RST;
            state_reg.used      <= `PBS_ADQ_ZERO;
            state_reg.rd_valid  <= 1'b0;
            state_reg.rd_data   <= 32'h0000_0000;
            state_reg.cpl_valid <= 1'b0;
            state_reg.cpl_id    <= 16'h0000;
            state_reg.acc       <= 1'b0;
            state_reg.dly       <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Outputs are straight flip-flop fields; the saturating usage count keeps
    // a stray release from wrapping the accounting below zero.
    assign rd_valid        = state_reg.rd_valid;
    assign rd_data         = state_reg.rd_data;
    assign cpl_id_valid    = state_reg.cpl_valid;
    assign cpl_id          = state_reg.cpl_id;
    assign sreq_accept     = state_reg.acc;
    assign sreq_delay      = state_reg.dly;
    assign adq_outstanding = state_reg.used[15:0];

endmodule // pbs_status

`default_nettype wire

// ---- verification/pbs_cfg_master.sv ----
// Configuration master on the primary bus, one access at a time.
// Assumes the block answers a self read at the taking edge, so rd_valid is seen 1 ns after it.
`timescale 1ns/1ps
`default_nettype none

module pbs_cfg_master (
    input  wire logic        clk_sys,
    input  wire logic        rd_valid,
    input  wire logic [31:0] rd_data,
    output var pbs_pkg::pbs_cfg_s cfg
);
    import pbs_pkg::*;
    initial cfg = '0;
    // Idle cycles show inverted fields so a stale value is never mistaken for a live one.
    task automatic acc(input logic w, input logic sel, input logic [31:0] ad, input logic [31:0] wd,
                       output logic ok, output logic [31:0] d);
        @(posedge clk_sys);
        cfg <= '{valid: 1'b1, write: w, idsel: sel, ad: ad, wdata: wd, be: 4'hF};
        @(posedge clk_sys);
        cfg <= '{valid: 1'b0, write: !w, idsel: !sel, ad: ~ad, wdata: ~wd, be: 4'h0};
        #1;
        ok = rd_valid;
        d = rd_data;
    endtask
endmodule // pbs_cfg_master
`default_nettype wire

// ---- verification/pbs_status_props.sv ----
// Assertions on the status register ports.
// Assumes one clock and the asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_params.svh"

module pbs_status_props (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              reverse_mode,
    input wire pbs_pkg::pbs_cfg_s cfg,
    input wire logic [7:0]        prim_bus_num,
    input wire pbs_pkg::pbs_sreq_s sreq,
    input wire logic              limit_load,
    input wire logic [15:0]       limit_value,
    input wire logic              adq_release,
    input wire logic              rd_valid,
    input wire logic [31:0]       rd_data,
    input wire logic              cpl_id_valid,
    input wire logic [15:0]       cpl_id,
    input wire logic              sreq_accept,
    input wire logic              sreq_delay,
    input wire logic [15:0]       adq_outstanding
);
    import pbs_pkg::*;
    // --------
    // Helper logic
    // --------
    logic [15:0] lim;
    logic [16:0] want;
    logic        self_rd;
    assign want = {1'b0, adq_outstanding} + {1'b0, sreq.adq};
    assign self_rd = cfg.valid && !cfg.write && cfg.idsel && cfg.ad[1:0] == 2'h0 && cfg.ad[10:8] == 3'h0;
    // The limit is mirrored here because the register that holds it lives elsewhere.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) lim <= `PBS_LIMIT_RST;
        else if (limit_load) lim <= limit_value;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // --------
    // Assertions
    // --------
    chk_self_read: assert property (self_rd |=> rd_valid && cpl_id_valid)
        else $error("self read not answered");
    chk_foreign_quiet: assert property (cfg.valid && !self_rd |=> !rd_valid)
        else $error("answer without self read");
    chk_fixed_zero: assert property (rd_valid |-> rd_data[2:0] == 3'h0 && rd_data[31:22] == 10'h0
        && !rd_data[20] && !rd_data[18] && !rd_data[16]) else $error("fixed bits not zero");
    chk_bus_alias: assert property (rd_valid && $past(prim_bus_num, 2) == $past(prim_bus_num)
        |-> rd_data[15:8] == $past(prim_bus_num)) else $error("bus field wrong");
    chk_cpl_id: assert property (cpl_id_valid && $past(cfg.ad[7:2]) == 6'h21 |-> cpl_id == rd_data[15:0])
        else $error("completer id wrong");
    chk_fast_flag: assert property (rd_valid |-> rd_data[17] == reverse_mode)
        else $error("fast flag wrong");
    chk_delay_over: assert property (sreq.valid && !adq_release && !limit_load && want > {1'b0, lim}
        |=> sreq_delay && !sreq_accept) else $error("request not delayed");
    chk_accept_fit: assert property (sreq.valid && !adq_release && !limit_load && want <= {1'b0, lim}
        |=> sreq_accept && !sreq_delay) else $error("request not accepted");
    chk_accept_add: assert property (sreq_accept && !$past(adq_release)
        |-> adq_outstanding == $past(adq_outstanding) + $past(sreq.adq)) else $error("usage wrong");
    cover property (sreq_delay);
    cover property (sreq_accept);
    cover property (rd_valid && rd_data[19]);
endmodule // pbs_status_props

bind pbs_status pbs_status_props chk_u (.clk_sys, .rst, .reverse_mode, .cfg, .prim_bus_num, .sreq,
    .limit_load, .limit_value, .adq_release, .rd_valid, .rd_data, .cpl_id_valid, .cpl_id,
    .sreq_accept, .sreq_delay, .adq_outstanding);
`default_nettype wire

// ---- verification/pbs_status_tb.sv ----
// Self-checking bench for the status register block.
// Assumes the design, package and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module pbs_status_tb;
    import pbs_pkg::*;
    logic clk_sys = 0, rst = 1, reverse_mode = 0, limit_load = 0, adq_release = 0;
    logic [7:0] prim_bus_num = 8'hA5;
    logic [15:0] limit_value = 16'h0, adq_release_cnt = 16'h0, cpl_id, adq_outstanding;
    pbs_scmp_s scmp = '0;
    pbs_sreq_s sreq = '0;
    pbs_cfg_s cfg;
    logic rd_valid, cpl_id_valid, sreq_accept, sreq_delay, ok;
    logic [31:0] rd_data, d;
    logic [31:0] bad [3] = '{32'h84, 32'h85, 32'h184};
    int n_mismatch = 0, total_checks = 0;

    pbs_status dut_u (.clk_sys, .rst, .reverse_mode, .cfg, .prim_bus_num, .scmp, .sreq, .limit_load,
        .limit_value, .adq_release, .adq_release_cnt, .rd_valid, .rd_data, .cpl_id_valid, .cpl_id,
        .sreq_accept, .sreq_delay, .adq_outstanding);
    pbs_cfg_master master_u (.clk_sys, .rd_valid, .rd_data, .cfg);

    initial begin
        forever #25 clk_sys = !clk_sys;
    end
    // --------
    // Tasks
    // --------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [31:0] e);
        master_u.acc(1'b0, 1'b1, 32'h84, 32'h0, ok, d);
        chk("cpl valid", 1, cpl_id_valid);
        chk("answer", 1, ok);
        chk("status", e, d);
    endtask
    task automatic wr(input logic [31:0] ad, input logic [31:0] wd);
        master_u.acc(1'b1, 1'b1, ad, wd, ok, d);
        chk("write quiet", 0, ok);
    endtask
    task automatic req(input logic [15:0] a, input logic dly);
        @(posedge clk_sys);
        sreq <= '{1'b1, a};
        @(posedge clk_sys);
        sreq <= '{1'b0, ~a};
        #1;
        chk("delay", dly, sreq_delay);
        chk("accept", !dly, sreq_accept);
    endtask
    task automatic cmp(input logic [15:0] id);
        @(posedge clk_sys);
        scmp <= '{1'b1, id, 16'h0};
        @(posedge clk_sys);
        scmp <= '{1'b0, ~id, 16'hFFFF};
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // --------
    // Tests
    // --------
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        summarize();
    end
    initial begin
        do_reset();
        rd(32'h0000A5F8);
        chk("cpl id", 16'hA5F8, cpl_id);
        for (int i = 0; i < 3; i++) begin
            master_u.acc(1'b0, i != 0, bad[i], 32'h0, ok, d);
            chk("foreign read", 0, ok);
            master_u.acc(1'b1, i != 0, bad[i] | 32'h3800, 32'hFFFFFFFF, ok, d);
            chk("foreign write", 0, ok);
        end
        rd(32'h0000A5F8);
        wr(32'h5088, 32'hFFFFFFFF);
        rd(32'h0000A550);
        chk("cpl id", 16'hA550, cpl_id);
        cmp(16'hA551);
        rd(32'h0000A550);
        cmp(16'hA550);
        rd(32'h0008A550);
        wr(32'h5084, 32'h0);
        rd(32'h0008A550);
        wr(32'h5084, 32'h00080000);
        rd(32'h0000A550);
        req(16'h10, 1'b0);
        chk("outstanding", 16'h10, adq_outstanding);
        req(16'h1, 1'b1);
        rd(32'h0020A550);
        @(posedge clk_sys);
        adq_release <= 1'b1;
        limit_load <= 1'b1;
        adq_release_cnt <= 16'h20;
        limit_value <= 16'h20;
        @(posedge clk_sys);
        adq_release <= 1'b0;
        limit_load <= 1'b0;
        #1;
        chk("outstanding", 0, adq_outstanding);
        req(16'h20, 1'b0);
        req(16'h1, 1'b1);
        wr(32'h5084, 32'h00200000);
        rd(32'h0000A550);
        prim_bus_num <= 8'h3C;
        reverse_mode <= 1'b1;
        do_reset();
        rd(32'h00023CF8);
        cmp(16'h3CF8);
        wr(32'hF884, 32'h00080000);
        rd(32'h000A3CF8);
        summarize();
    end
endmodule // pbs_status_tb
`default_nettype wire
